// ### aoc_pkg.sv
/*
 * aoc_pkg: word map, field layout, reset values and value ranges of the
 * analog output configuration map.
 * Assumes word addresses are plain binary word indices on the host port.
 */
package aoc_pkg;
    localparam int NPTS = 8;
    localparam int WW = 16;
    localparam int AW = 7;
    localparam int NLIM = 2 * NPTS;

    // word indices
    localparam logic [AW-1:0] W_INVALID = 7'h00;
    localparam logic [AW-1:0] W_CONV0 = 7'h01;
    localparam logic [AW-1:0] W_FEATURE_STATUS_A = 7'h09;
    localparam logic [AW-1:0] W_FEATURE_STATUS_B = 7'h0A;
    localparam logic [AW-1:0] W_POINT_ENABLED_STATUS = 7'h0B;
    localparam logic [AW-1:0] W_BLOCK_READ_POINTER = 7'h0C;
    localparam logic [AW-1:0] W_SCALE_RAMP_ENABLE = 7'h0D;
    localparam logic [AW-1:0] W_CLAMP_FORMAT_SELECT = 7'h0E;
    localparam logic [AW-1:0] W_POINT_CONVERT_ENABLE = 7'h0F;
    localparam logic [AW-1:0] W_SPEED_SELECT = 7'h10;
    localparam logic [AW-1:0] W_LIM0 = 7'h29;

    // byte positions of the per-point bit fields inside a control word
    localparam int LO_BYTE = 0;
    localparam int HI_BYTE = 8;

    // reset values, speed codes and the zero word
    localparam logic [WW-1:0] RST_POINTER = 16'h0000;
    localparam logic [NPTS-1:0] RST_SCALE = 8'h00;
    localparam logic [NPTS-1:0] RST_RAMP = 8'h00;
    localparam logic [NPTS-1:0] RST_CLAMP = 8'h00;
    localparam logic [NPTS-1:0] RST_FMT_BCD = 8'hFF;
    localparam logic [NPTS-1:0] RST_CONV_EN = 8'hFF;
    localparam logic [NPTS-1:0] RST_FLAGS = 8'h00;
    localparam logic [WW-1:0] SPEED_NORMAL = 16'h0000;
    localparam logic [WW-1:0] SPEED_HIGH = 16'hFFFF;
    localparam logic [WW-1:0] ZERO_WORD = 16'h0000;

    // value ranges
    localparam logic [WW-1:0] BIN_NEG_FULL = 16'h8000;
    localparam int SIGN_BIT = 15;
    localparam int BCD_MAX_DIGIT = 9;
    localparam int BCD_MAX_TOP = 7;
    localparam int UNI_MIN = 0;
    localparam int UNI_MAX = 4095;
    localparam int BIP_MIN = -2048;
    localparam int BIP_MAX = 2047;
    localparam int BIP_MAX_BCD = 2048;
    localparam int POINTER_MAX = 61;
endpackage

// ### aoc_config_map.sv
/*
 * aoc_config_map: configuration and status words of an eight-point analog
 * output unit, with the conversion data words, their range check and the
 * upper/lower clamp, reached by host block writes and pointer block reads.
 * Assumes the host port is synchronous to clk and carries one word a cycle.
 */
`timescale 1ns/1ps
module aoc_config_map (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // host block write
    input wire logic host_wr,
    input wire logic host_wr_single,
    input wire logic [aoc_pkg::AW-1:0] host_addr,
    input wire logic [aoc_pkg::WW-1:0] host_wdata,
    // host block read through the pointer
    input wire logic host_rd,
    input wire logic [aoc_pkg::AW-1:0] host_rd_index,
    output logic [aoc_pkg::WW-1:0] host_rdata,
    output logic host_rvalid,
    // output range of each point
    input wire logic [aoc_pkg::NPTS-1:0] range_bipolar,
    // to the converter
    output logic [aoc_pkg::NPTS-1:0][aoc_pkg::WW-1:0] conv_word,
    output logic [aoc_pkg::NPTS-1:0] point_active,
    output logic [aoc_pkg::NPTS-1:0] scale_on,
    output logic [aoc_pkg::NPTS-1:0] ramp_on,
    output logic [aoc_pkg::NPTS-1:0] format_bcd,
    output logic high_speed,
    output logic [aoc_pkg::NPTS-1:0] invalid_data
);
    import aoc_pkg::*;

    typedef logic signed [17:0] aoc_val_t;

    typedef struct packed {
        logic [NPTS-1:0] scale_en;
        logic [NPTS-1:0] ramp_en;
        logic [NPTS-1:0] clamp_en;
        logic [NPTS-1:0] fmt_bcd;
        logic [NPTS-1:0] conv_en;
        logic [WW-1:0] speed;
        logic [WW-1:0] pointer;
        logic [NPTS-1:0] scale_flag;
        logic [NPTS-1:0] ramp_flag;
        logic [NPTS-1:0] clamp_flag;
        logic [NPTS-1:0] fmt_flag;
        logic [NPTS-1:0] conv_flag;
        logic [NPTS-1:0] invalid;
        logic [NPTS-1:0][WW-1:0] conv;
        logic [NLIM-1:0][WW-1:0] lim;
        logic [WW-1:0] rdata;
        logic rvalid;
    } aoc_state_t;

    aoc_state_t state_reg;
    aoc_state_t state_next;

    // numeric value of a data word in the point's format
    function automatic aoc_val_t word_value(input logic [WW-1:0] w, input logic bcd);
        aoc_val_t mag;
        mag = 18'(w[3:0]) + 18'(w[7:4]) * 18'sd10 + 18'(w[11:8]) * 18'sd100
            + 18'(w[14:12]) * 18'sd1000;
        if (bcd) begin
            word_value = w[SIGN_BIT] ? -mag : mag;
        end else begin
            word_value = 18'(signed'(w));
        end
    endfunction

    // acceptable data word for the point's format, scaling and range
    function automatic logic word_ok(input logic [WW-1:0] w, input logic bcd,
                                     input logic scaled, input logic bip);
        aoc_val_t v;
        logic digits_ok;
        v = word_value(w, bcd);
        digits_ok = (int'(w[3:0]) <= BCD_MAX_DIGIT) && (int'(w[7:4]) <= BCD_MAX_DIGIT)
            && (int'(w[11:8]) <= BCD_MAX_DIGIT) && (int'(w[15:12]) <= BCD_MAX_DIGIT);
        if (bcd && !scaled) begin
            digits_ok = digits_ok || (w[SIGN_BIT] && int'(w[14:12]) <= BCD_MAX_TOP
                && int'(w[11:8]) <= BCD_MAX_DIGIT && int'(w[7:4]) <= BCD_MAX_DIGIT
                && int'(w[3:0]) <= BCD_MAX_DIGIT);
        end
        if (bcd && scaled) begin
            digits_ok = (int'(w[14:12]) <= BCD_MAX_TOP) && (int'(w[11:8]) <= BCD_MAX_DIGIT)
                && (int'(w[7:4]) <= BCD_MAX_DIGIT) && (int'(w[3:0]) <= BCD_MAX_DIGIT);
        end
        if (scaled) begin
            // full signed engineering range
            word_ok = bcd ? digits_ok : (w != BIN_NEG_FULL);
        end else if (bip) begin
            word_ok = (bcd ? digits_ok : 1'b1) && (v >= aoc_val_t'(BIP_MIN))
                && (v <= (bcd ? aoc_val_t'(BIP_MAX_BCD) : aoc_val_t'(BIP_MAX)));
        end else begin
            word_ok = (bcd ? digits_ok : 1'b1) && (v >= aoc_val_t'(UNI_MIN))
                && (v <= aoc_val_t'(UNI_MAX));
        end
    endfunction

    // binary word index from a BCD pointer
    function automatic logic [AW-1:0] bcd_index(input logic [WW-1:0] p);
        // widen before the product so tens above one do not wrap in four bits
        bcd_index = AW'(p[3:0]) + AW'(p[7:4]) * AW'(10);
    endfunction

    logic [AW-1:0] rd_addr;
    logic [WW-1:0] rd_word;
    logic [NPTS-1:0] pt_wr;
    logic [NPTS-1:0] pt_ok;
    logic [NPTS-1:0][WW-1:0] pt_stored;

    assign rd_addr = bcd_index(state_reg.pointer) + host_rd_index;

    // per-point write of conversion data: range check and clamp
    generate
        for (genvar p = 0; p < NPTS; p++) begin : g_point
            logic [WW-1:0] lo_w;
            logic [WW-1:0] hi_w;
            aoc_val_t v;
            assign lo_w = state_reg.lim[2*p];
            assign hi_w = state_reg.lim[2*p+1];
            // the point's own format decodes data and both limits
            assign v = word_value(host_wdata, state_reg.fmt_bcd[p]);
            assign pt_wr[p] = host_wr && (host_addr == W_CONV0 + AW'(p));
            assign pt_ok[p] = word_ok(host_wdata, state_reg.fmt_bcd[p],
                state_reg.scale_en[p], range_bipolar[p]);
            always_comb begin
                pt_stored[p] = host_wdata;
                if (state_reg.clamp_en[p]) begin
                    if (v > word_value(hi_w, state_reg.fmt_bcd[p])) begin
                        pt_stored[p] = hi_w;
                    end else if (v < word_value(lo_w, state_reg.fmt_bcd[p])) begin
                        pt_stored[p] = lo_w;
                    end
                end
            end
        end
    endgenerate

    // read word at the pointer-relative address
    always_comb begin
        rd_word = ZERO_WORD;
        if (rd_addr == W_INVALID) begin
            rd_word[LO_BYTE +: NPTS] = state_reg.invalid;
        end else if (rd_addr >= W_CONV0 && rd_addr < W_CONV0 + AW'(NPTS)) begin
            rd_word = state_reg.conv[rd_addr - W_CONV0];
        end else if (rd_addr >= W_LIM0 && rd_addr < W_LIM0 + AW'(NLIM)) begin
            rd_word = state_reg.lim[rd_addr - W_LIM0];
        end else begin
            unique case (rd_addr)
                W_FEATURE_STATUS_A: begin
                    rd_word = {state_reg.ramp_flag, state_reg.scale_flag};
                end
                W_FEATURE_STATUS_B: begin
                    rd_word = {state_reg.fmt_flag, state_reg.clamp_flag};
                end
                W_POINT_ENABLED_STATUS: begin
                    rd_word[LO_BYTE +: NPTS] = state_reg.conv_flag;
                end
                W_BLOCK_READ_POINTER: begin
                    rd_word = state_reg.pointer;
                end
                W_SCALE_RAMP_ENABLE: begin
                    rd_word = {state_reg.ramp_en, state_reg.scale_en};
                end
                W_CLAMP_FORMAT_SELECT: begin
                    rd_word = {state_reg.fmt_bcd, state_reg.clamp_en};
                end
                W_POINT_CONVERT_ENABLE: begin
                    rd_word[LO_BYTE +: NPTS] = state_reg.conv_en;
                end
                W_SPEED_SELECT: begin
                    rd_word = state_reg.speed;
                end
                default: begin
                    rd_word = ZERO_WORD;
                end
            endcase
        end
    end

    always_comb begin
        state_next = state_reg;
        // mirrors trail the control words by one cycle
        state_next.scale_flag = state_reg.scale_en;
        state_next.ramp_flag = state_reg.ramp_en;
        state_next.clamp_flag = state_reg.clamp_en;
        state_next.fmt_flag = state_reg.fmt_bcd;
        state_next.conv_flag = state_reg.conv_en;
        state_next.rvalid = host_rd;
        if (host_rd) begin
            state_next.rdata = rd_word;
        end
        for (int p = 0; p < NPTS; p++) begin
            if (pt_wr[p]) begin
                state_next.invalid[p] = !pt_ok[p];
                if (pt_ok[p]) begin
                    state_next.conv[p] = pt_stored[p];
                end
            end
        end
        if (host_wr) begin
            if (host_addr >= W_LIM0 && host_addr < W_LIM0 + AW'(NLIM)) begin
                state_next.lim[host_addr - W_LIM0] = host_wdata;
            end
            unique case (host_addr)
                W_BLOCK_READ_POINTER: begin
                    // only a one-word write to a legal BCD start moves it
                    if (host_wr_single && int'(bcd_index(host_wdata)) <= POINTER_MAX
                        && int'(host_wdata[3:0]) <= BCD_MAX_DIGIT
                        && host_wdata[WW-1:8] == 8'h00) begin
                        state_next.pointer = host_wdata;
                    end
                end
                W_SCALE_RAMP_ENABLE: begin
                    state_next.scale_en = host_wdata[LO_BYTE +: NPTS];
                    state_next.ramp_en = host_wdata[HI_BYTE +: NPTS];
                end
                W_CLAMP_FORMAT_SELECT: begin
                    state_next.clamp_en = host_wdata[LO_BYTE +: NPTS];
                    state_next.fmt_bcd = host_wdata[HI_BYTE +: NPTS];
                end
                W_POINT_CONVERT_ENABLE: begin
                    state_next.conv_en = host_wdata[LO_BYTE +: NPTS];
                end
                W_SPEED_SELECT: begin
                    if (host_wdata == SPEED_NORMAL || host_wdata == SPEED_HIGH) begin
                        state_next.speed = host_wdata;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
            state_reg.scale_en <= RST_SCALE;
            state_reg.ramp_en <= RST_RAMP;
            state_reg.clamp_en <= RST_CLAMP;
            state_reg.fmt_bcd <= RST_FMT_BCD;
            state_reg.conv_en <= RST_CONV_EN;
            state_reg.speed <= SPEED_NORMAL;
            state_reg.pointer <= RST_POINTER;
            state_reg.scale_flag <= RST_FLAGS;
            state_reg.fmt_flag <= RST_FMT_BCD;
            state_reg.invalid <= RST_FLAGS;
        end else begin
            state_reg <= state_next;
        end
    end

    // disabled points present a zero word to the converter
    always_comb begin
        for (int p = 0; p < NPTS; p++) begin
            conv_word[p] = state_reg.conv_en[p] ? state_reg.conv[p] : ZERO_WORD;
        end
    end

    assign point_active = state_reg.conv_en;
    assign scale_on = state_reg.scale_en;
    assign ramp_on = state_reg.ramp_en;
    assign format_bcd = state_reg.fmt_bcd;
    assign high_speed = (state_reg.speed == SPEED_HIGH);
    assign invalid_data = state_reg.invalid;
    assign host_rdata = state_reg.rdata;
    assign host_rvalid = state_reg.rvalid;
endmodule

// ### aoc_config_map_assertions.sv
/*
 * aoc_config_map_assertions: port checks of the configuration map.
 * Assumes one clock domain; bound to the map at the foot of this file.
 */
`timescale 1ns/1ps
module aoc_config_map_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // host port
    input wire logic host_wr,
    input wire logic [aoc_pkg::AW-1:0] host_addr,
    input wire logic [aoc_pkg::WW-1:0] host_wdata,
    input wire logic host_rd,
    input wire logic [aoc_pkg::WW-1:0] host_rdata,
    input wire logic host_rvalid,
    // converter side
    input wire logic [aoc_pkg::NPTS-1:0][aoc_pkg::WW-1:0] conv_word,
    input wire logic [aoc_pkg::NPTS-1:0] point_active,
    input wire logic [aoc_pkg::NPTS-1:0] scale_on,
    input wire logic [aoc_pkg::NPTS-1:0] ramp_on,
    input wire logic [aoc_pkg::NPTS-1:0] format_bcd,
    input wire logic high_speed,
    input wire logic [aoc_pkg::NPTS-1:0] invalid_data
);
    import aoc_pkg::*;
    logic [WW-1:0] wd_q;
    logic dis_bad;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // write data of the previous edge
    always_ff @(posedge clk) begin
        wd_q <= host_wdata;
    end
    always_comb begin
        dis_bad = 1'b0;
        for (int i = 0; i < NPTS; i++) begin
            if (!point_active[i] && conv_word[i] != ZERO_WORD) dis_bad = 1'b1;
        end
    end
    AST_SCALE: assert property (host_wr && host_addr == W_SCALE_RAMP_ENABLE |=>
        scale_on == wd_q[7:0] && ramp_on == wd_q[15:8]) else $error("scale or ramp not stored");
    AST_FORMAT: assert property (host_wr && host_addr == W_CLAMP_FORMAT_SELECT |=>
        format_bcd == wd_q[15:8]) else $error("format bits not stored");
    AST_PT_EN: assert property (host_wr && host_addr == W_POINT_CONVERT_ENABLE |=>
        point_active == wd_q[7:0]) else $error("point enables not stored");
    AST_HOLD: assert property (!host_wr |=> $stable(scale_on) && $stable(ramp_on)
        && $stable(format_bcd) && $stable(point_active)) else $error("control moved unasked");
    AST_SPEED_HI: assert property (host_wr && host_addr == W_SPEED_SELECT
        && host_wdata == SPEED_HIGH |=> high_speed) else $error("high speed not taken");
    AST_SPEED_BAD: assert property (host_wr && host_addr == W_SPEED_SELECT
        && host_wdata != SPEED_HIGH && host_wdata != SPEED_NORMAL |=> $stable(high_speed))
        else $error("illegal speed value taken");
    AST_RVALID: assert property (host_rd |=> host_rvalid) else $error("read not answered");
    AST_RQUIET: assert property (!host_rd |=> !host_rvalid && $stable(host_rdata))
        else $error("read data moved unasked");
    AST_CONV_DIS: assert property (!dis_bad) else $error("disabled point drives data");
    AST_BAD_BIN: assert property (host_wr && host_addr == W_CONV0 && scale_on[0]
        && !format_bcd[0] && host_wdata == BIN_NEG_FULL |=> invalid_data[0]
        && $stable(conv_word[0])) else $error("bad binary value accepted");
    cover property (host_wr && host_addr == W_SPEED_SELECT && host_wdata == SPEED_HIGH);
    cover property ($rose(invalid_data[0]));
    cover property ($fell(point_active[0]));
endmodule
bind aoc_config_map aoc_config_map_assertions u_chk (
    .clk(clk), .reset(reset), .host_wr(host_wr), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_rd(host_rd), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .conv_word(conv_word), .point_active(point_active),
    .scale_on(scale_on), .ramp_on(ramp_on), .format_bcd(format_bcd),
    .high_speed(high_speed), .invalid_data(invalid_data));

// ### aoc_host_model.sv
/*
 * aoc_host_model: host CPU side, one-word block writes and pointer reads.
 * Assumes the map samples on the rising edge; this model drives on the falling one.
 */
`timescale 1ns/1ps
module aoc_host_model (
    // clock
    input wire logic clk,
    // requests
    output logic host_wr,
    output logic host_wr_single,
    output logic [aoc_pkg::AW-1:0] host_addr,
    output logic [aoc_pkg::WW-1:0] host_wdata,
    output logic host_rd,
    output logic [aoc_pkg::AW-1:0] host_rd_index,
    // answers
    input wire logic [aoc_pkg::WW-1:0] host_rdata,
    input wire logic host_rvalid
);
    import aoc_pkg::*;
    initial begin
        {host_wr, host_wr_single, host_rd} = 3'h0;
        host_addr = 7'h00;
        host_wdata = 16'h0000;
        host_rd_index = 7'h00;
    end
    task automatic wr(input logic [AW-1:0] a, input logic [WW-1:0] d, input logic single);
        @(negedge clk);
        host_wr = 1'b1;
        host_wr_single = single;
        host_addr = a;
        host_wdata = d;
        @(negedge clk);
        {host_wr, host_wr_single} = 2'h0;
        // released lines show the inverse, never the old value
        host_addr = ~a;
        host_wdata = ~d;
    endtask
    // read answer comes one cycle after the request
    task automatic rd(input logic [AW-1:0] i, output logic [WW-1:0] d);
        @(negedge clk);
        host_rd = 1'b1;
        host_rd_index = i;
        @(negedge clk);
        host_rd = 1'b0;
        host_rd_index = ~i;
        d = host_rdata;
    endtask
endmodule

// ### tb.sv
/*
 * tb: self-checking bench of the configuration map, driven through the host model.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
module tb;
    import aoc_pkg::*;
    logic clk, reset, host_wr, host_wr_single, host_rd, host_rvalid, high_speed;
    logic [AW-1:0] host_addr, host_rd_index;
    logic [WW-1:0] host_wdata, host_rdata;
    logic [NPTS-1:0] range_bipolar, point_active, scale_on, ramp_on, format_bcd, invalid_data;
    logic [NPTS-1:0][WW-1:0] conv_word;
    int num_errors;
    int checks;
    aoc_config_map u_dut (.clk(clk), .reset(reset), .host_wr(host_wr),
        .host_wr_single(host_wr_single), .host_addr(host_addr), .host_wdata(host_wdata),
        .host_rd(host_rd), .host_rd_index(host_rd_index), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .range_bipolar(range_bipolar), .conv_word(conv_word),
        .point_active(point_active), .scale_on(scale_on), .ramp_on(ramp_on),
        .format_bcd(format_bcd), .high_speed(high_speed), .invalid_data(invalid_data));
    aoc_host_model u_host (.clk(clk), .host_wr(host_wr), .host_wr_single(host_wr_single),
        .host_addr(host_addr), .host_wdata(host_wdata), .host_rd(host_rd),
        .host_rd_index(host_rd_index), .host_rdata(host_rdata), .host_rvalid(host_rvalid));
    always #5 clk = ~clk;
    task automatic chk(input string n, input logic [WW-1:0] e, input logic [WW-1:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input logic [AW-1:0] i, input logic [WW-1:0] e);
        logic [WW-1:0] d;
        u_host.rd(i, d);
        chk("read word", e, d);
    endtask
    // one write to point 0 data, then its stored word and invalid flag
    task automatic cw(input logic [WW-1:0] d, input logic [WW-1:0] e, input logic inv);
        u_host.wr(W_CONV0, d, 1'b0);
        chk("conv_word", e, conv_word[0]);
        chk("invalid_data", {15'h0000, inv}, {15'h0000, invalid_data[0]});
    endtask
    task automatic t_reset();
        chk("format_bcd", 16'h00FF, {8'h00, format_bcd});
        rchk(7'h09, 16'h0000);
        rchk(7'h0A, 16'hFF00);
        rchk(7'h0B, 16'h00FF);
        rchk(7'h0C, 16'h0000);
        rchk(7'h0D, 16'h0000);
        rchk(7'h0E, 16'hFF00);
        rchk(7'h0F, 16'h00FF);
        rchk(7'h10, 16'h0000);
    endtask
    task automatic t_mirror();
        u_host.wr(7'h0D, 16'hA55A, 1'b0);
        chk("scale_on", 16'h005A, {8'h00, scale_on});
        chk("ramp_on", 16'h00A5, {8'h00, ramp_on});
        u_host.wr(7'h0E, 16'h3C0F, 1'b0);
        u_host.wr(7'h0F, 16'h0081, 1'b0);
        chk("point_active", 16'h0081, {8'h00, point_active});
        u_host.wr(7'h09, 16'hFFFF, 1'b0);
        rchk(7'h09, 16'hA55A);
        rchk(7'h0A, 16'h3C0F);
        rchk(7'h0B, 16'h0081);
    endtask
    task automatic t_pointer();
        u_host.wr(7'h0C, 16'h0010, 1'b1);
        rchk(7'h00, 16'h3C0F);
        u_host.wr(7'h0C, 16'h0061, 1'b1);
        rchk(7'h4E, 16'h0081);
        u_host.wr(7'h0C, 16'h0062, 1'b1);
        u_host.wr(7'h0C, 16'h0013, 1'b0);
        rchk(7'h4E, 16'h0081);
        u_host.wr(7'h0C, 16'h0000, 1'b1);
    endtask
    task automatic t_speed();
        u_host.wr(7'h10, 16'hFFFF, 1'b0);
        rchk(7'h10, 16'hFFFF);
        u_host.wr(7'h10, 16'h1234, 1'b0);
        chk("high_speed", 16'h0001, {15'h0000, high_speed});
        u_host.wr(7'h10, 16'h0000, 1'b0);
        chk("high_speed", 16'h0000, {15'h0000, high_speed});
    endtask
    task automatic t_conv();
        u_host.wr(7'h0D, 16'h0001, 1'b0);
        u_host.wr(7'h0E, 16'h0001, 1'b0);
        u_host.wr(7'h29, 16'hFF00, 1'b0);
        u_host.wr(7'h2A, 16'h0100, 1'b0);
        cw(16'h0050, 16'h0050, 1'b0);
        cw(16'h0200, 16'h0100, 1'b0);
        cw(16'hF000, 16'hFF00, 1'b0);
        cw(16'h8000, 16'hFF00, 1'b1);
        cw(16'h7FFF, 16'h0100, 1'b0);
        u_host.wr(7'h0E, 16'h0101, 1'b0);
        u_host.wr(7'h29, 16'h8100, 1'b0);
        u_host.wr(7'h2A, 16'h0200, 1'b0);
        cw(16'h0300, 16'h0200, 1'b0);
        cw(16'h8500, 16'h8100, 1'b0);
        cw(16'h8A00, 16'h8100, 1'b1);
        u_host.wr(7'h0E, 16'h0100, 1'b0);
        cw(16'h7999, 16'h7999, 1'b0);
        cw(16'hF999, 16'hF999, 1'b0);
        rchk(7'h01, 16'hF999);
        u_host.wr(7'h0F, 16'h00FE, 1'b0);
        chk("conv_word", 16'h0000, conv_word[0]);
        // unscaled binary on a signed range, then back to the unsigned range
        u_host.wr(7'h0F, 16'h00FF, 1'b0);
        u_host.wr(7'h0D, 16'h0000, 1'b0);
        u_host.wr(7'h0E, 16'h0000, 1'b0);
        range_bipolar = 8'h01;
        cw(16'hF800, 16'hF800, 1'b0);
        cw(16'hF7FF, 16'hF800, 1'b1);
        range_bipolar = 8'h00;
        cw(16'hFFFF, 16'hF800, 1'b1);
        cw(16'h0FFF, 16'h0FFF, 1'b0);
    endtask
    task automatic results();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        results();
    end
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        range_bipolar = 8'h00;
        repeat (8) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        t_reset();
        t_mirror();
        t_pointer();
        t_speed();
        t_conv();
        results();
    end
endmodule
